// ---- src/bk1sf_pkg.sv ----
// shared constants and types for the bank 1 special function registers
package bk1sf_pkg;

   // register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_INDIRECT_DATA = 8'h80;
   localparam logic [7:0] IDX_OPTIONS       = 8'h81;
   localparam logic [7:0] IDX_PC_LOW        = 8'h82;
   localparam logic [7:0] IDX_FLAGS_BANK    = 8'h83;
   localparam logic [7:0] IDX_IND_POINTER   = 8'h84;
   localparam logic [7:0] IDX_PORT_A_DIR    = 8'h85;
   localparam logic [7:0] IDX_PORT_B_DIR    = 8'h86;
   localparam logic [7:0] IDX_PORT_C_DIR    = 8'h87;
   localparam logic [7:0] IDX_UPPER_PC      = 8'h8a;
   localparam logic [7:0] IDX_IRQ_CONTROL   = 8'h8b;
   localparam logic [7:0] IDX_PIE_A         = 8'h8c;
   localparam logic [7:0] IDX_PIE_B         = 8'h8d;
   localparam logic [7:0] IDX_RESET_CAUSE   = 8'h8e;
   localparam logic [7:0] IDX_T2_PERIOD     = 8'h92;
   localparam logic [7:0] IDX_SSP_ADDRESS   = 8'h93;
   localparam logic [7:0] IDX_SSP_STATE     = 8'h94;
   localparam logic [7:0] IDX_TX_CONTROL    = 8'h98;
   localparam logic [7:0] IDX_BAUD_DIVISOR  = 8'h99;

   // plain read/write registers held in generic cells
   localparam int N_SIMPLE = 10;
   localparam int SL_OPTIONS = 0;
   localparam int SL_PORT_A  = 1;
   localparam int SL_PORT_B  = 2;
   localparam int SL_PORT_C  = 3;
   localparam int SL_PIE_A   = 4;
   localparam int SL_PIE_B   = 5;
   localparam int SL_T2_PER  = 6;
   localparam int SL_SSP_ADR = 7;
   localparam int SL_BAUD    = 8;
   localparam int SL_TX_CTL  = 9;
   // entry [n] belongs to slot n
   localparam logic [N_SIMPLE-1:0][7:0] SIMPLE_IDX = {
      IDX_TX_CONTROL, IDX_BAUD_DIVISOR, IDX_SSP_ADDRESS, IDX_T2_PERIOD,
      IDX_PIE_B, IDX_PIE_A, IDX_PORT_C_DIR, IDX_PORT_B_DIR,
      IDX_PORT_A_DIR, IDX_OPTIONS};
   localparam logic [N_SIMPLE-1:0][7:0] SIMPLE_RST = {
      8'h02, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff,
      8'h3f, 8'hff};
   // implemented bits; the rest ignore writes and read zero, except tx control bit 1, which reads the shift-empty flag
   localparam logic [N_SIMPLE-1:0][7:0] SIMPLE_MSK = {
      8'hf5, 8'hff, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'hff,
      8'h3f, 8'hff};

   // flags-and-bank register fields
   localparam int FB_IND_BANK  = 7;
   localparam int FB_BANK_HIGH = 6;
   localparam int FB_BANK_LOW  = 5;
   localparam int FB_TIMEOUT   = 4;
   localparam int FB_POWERDOWN = 3;
   localparam int FB_ZERO      = 2;
   localparam int FB_DIGIT_CY  = 1;
   localparam int FB_CARRY     = 0;

   // other field positions and widths
   localparam int TX_SHIFT_EMPTY_BIT = 1;
   localparam int RC_POWER_ON_BIT    = 1;
   localparam int RC_BROWN_OUT_BIT   = 0;
   localparam int UPPER_PC_W         = 5;
   localparam int PC_W               = 13;
   localparam int SSP_STATE_W        = 6;

   // reset values
   localparam logic [7:0]      FLAGS_RST     = 8'h18;
   localparam logic [7:0]      UPPER_PC_RST  = 8'h00;
   localparam logic [7:0]      POINTER_RST   = 8'h00;
   localparam logic [7:0]      IRQ_CTRL_RST  = 8'h00;
   localparam logic [PC_W-1:0] PC_RST        = 13'h0000;
   localparam logic [PC_W-1:0] PC_ONE        = 13'h0001;

   // register contents handed to the core and peripherals
   typedef struct packed {
      logic [N_SIMPLE-1:0][7:0] simple;
      logic [7:0]               flags_bank;
      logic [7:0]               ind_pointer;
      logic [7:0]               upper_pc;
      logic [7:0]               irq_control;
      logic [7:0]               reset_cause;
      logic [PC_W-1:0]          pc;
   } bk1sf_regs_t;

endpackage

// ---- src/bk1sf_reg_cell.sv ----
// one generic 8-bit read/write register with reset value and bit mask
`timescale 1ns/1ps
`default_nettype none
module bk1sf_reg_cell #(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] MASK      = 8'hff
) (
   // clock and any-cause reset
   input  wire logic       clock,
   input  wire logic       rst,
   // write port
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   // contents
   output logic [7:0]      q
);
   logic [7:0] val_ff;

   // masked bits never store, so they cannot leak into reads
   always_ff @(posedge clock) begin
      if (rst) begin
         val_ff <= RESET_VAL & MASK;
      end else if (wr_en) begin
         val_ff <= wr_data & MASK;
      end
   end

   assign q = val_ff;
endmodule
`default_nettype wire

// ---- src/bk1sf_bank.sv ----
// bank 1 special function register bank behind an avalon-mm slave port
//
// Behaviour
// - unimplemented addresses and bits read back as zero.
// - the mirrored registers answer at the same function from either bank.
// - upper pc bits are hidden; a pc low write loads pc from the latch.
// - clear-pin and watchdog resets load the other-reset values.
// - on other resets unchanged bits keep state, conditional bits follow cause.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bk1sf_bank (
   // clock and power-class reset
   input  wire logic                 clock,
   input  wire logic                 nrst,
   // reset causes as one-cycle pulses, and the asleep level sampled on other resets
   input  wire logic                 brown_out_reset,
   input  wire logic                 external_clear_pin,
   input  wire logic                 watchdog_timeout,
   input  wire logic                 asleep,
   // core program counter advance
   input  wire logic                 pc_step,
   // peripheral status
   input  wire logic [5:0]           ssp_state_in,
   input  wire logic                 tx_shift_empty,
   // avalon-mm slave
   input  wire logic [9:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   // register contents
   output bk1sf_pkg::bk1sf_regs_t    regs
);

   // reset classes; brown-out counts with power-on
   logic por_rst;
   logic oth_rst;
   logic any_rst;
   assign por_rst = !nrst || brown_out_reset;
   assign oth_rst = external_clear_pin || watchdog_timeout;
   assign any_rst = por_rst || oth_rst;

   // register state
   logic [bk1sf_pkg::N_SIMPLE-1:0][7:0] simple_q;
   logic [bk1sf_pkg::N_SIMPLE-1:0]      simple_we;
   logic [7:0]                          flags_ff;
   logic [7:0]                          pointer_ff;
   logic [7:0]                          upper_pc_ff;
   logic [7:0]                          irq_ctrl_ff;
   logic [1:0]                          cause_ff;
   logic [bk1sf_pkg::PC_W-1:0]          pc_ff;
   logic [5:0]                          ssp_state_ff;
   logic                                tx_empty_ff;

   // bus handshake state
   logic       ack_ff;
   logic [7:0] rdata_ff;
   logic       req;
   logic       wr_commit;

   // address decode
   logic [7:0] bus_idx;
   logic [8:0] direct_map;
   logic [8:0] indirect_map;
   logic       acc_ok;
   logic [7:0] eff_idx;
   logic [7:0] wdata;
   logic [7:0] rd_val;

   // implemented locations of bank 1
   function automatic logic is_impl(input logic [7:0] m);
      unique case (m)
         bk1sf_pkg::IDX_INDIRECT_DATA, bk1sf_pkg::IDX_OPTIONS,
         bk1sf_pkg::IDX_PC_LOW, bk1sf_pkg::IDX_FLAGS_BANK,
         bk1sf_pkg::IDX_IND_POINTER, bk1sf_pkg::IDX_PORT_A_DIR,
         bk1sf_pkg::IDX_PORT_B_DIR, bk1sf_pkg::IDX_PORT_C_DIR,
         bk1sf_pkg::IDX_UPPER_PC, bk1sf_pkg::IDX_IRQ_CONTROL,
         bk1sf_pkg::IDX_PIE_A, bk1sf_pkg::IDX_PIE_B,
         bk1sf_pkg::IDX_RESET_CAUSE, bk1sf_pkg::IDX_T2_PERIOD,
         bk1sf_pkg::IDX_SSP_ADDRESS, bk1sf_pkg::IDX_SSP_STATE,
         bk1sf_pkg::IDX_TX_CONTROL, bk1sf_pkg::IDX_BAUD_DIVISOR:
            is_impl = 1'b1;
         default:
            is_impl = 1'b0;
      endcase
   endfunction

   // locations that also answer from bank 0
   function automatic logic is_mirror(input logic [7:0] m);
      unique case (m)
         bk1sf_pkg::IDX_INDIRECT_DATA, bk1sf_pkg::IDX_PC_LOW,
         bk1sf_pkg::IDX_FLAGS_BANK, bk1sf_pkg::IDX_IND_POINTER,
         bk1sf_pkg::IDX_UPPER_PC, bk1sf_pkg::IDX_IRQ_CONTROL:
            is_mirror = 1'b1;
         default:
            is_mirror = 1'b0;
      endcase
   endfunction

   // folds a data address onto bank 1; bit 8 tells whether it is ours
   function automatic logic [8:0] map_idx(input logic [7:0] i);
      logic [7:0] m;
      logic       ok;
      m  = {1'b1, i[6:0]};
      ok = (i[6:5] == 2'b00) && is_impl(m) && (i[7] || is_mirror(m));
      map_idx = {ok, m};
   endfunction

   // a pointer aimed at the data port itself reaches nothing
   always_comb begin
      bus_idx      = avs_address[9:2];
      direct_map   = map_idx(bus_idx);
      indirect_map = map_idx(pointer_ff);
      if (direct_map[7:0] == bk1sf_pkg::IDX_INDIRECT_DATA) begin
         acc_ok  = direct_map[8] && indirect_map[8] &&
                   (indirect_map[7:0] != bk1sf_pkg::IDX_INDIRECT_DATA);
         eff_idx = indirect_map[7:0];
      end else begin
         acc_ok  = direct_map[8];
         eff_idx = direct_map[7:0];
      end
   end

   // one wait state: readdata is loaded while waitrequest is high
   assign req             = avs_read || avs_write;
   assign avs_waitrequest = req && !ack_ff;
   assign wdata           = avs_writedata[7:0];
   // lane 0 carries the byte; an unmapped target drops the write
   assign wr_commit = avs_write && ack_ff && avs_byteenable[0] && acc_ok &&
                      !any_rst;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req && !ack_ff;
      end
   end

   // read mux; holes and unused bits give zero
   always_comb begin
      rd_val = 8'h00;
      if (acc_ok) begin
         for (int s = 0; s < bk1sf_pkg::N_SIMPLE; s++) begin
            if (eff_idx == bk1sf_pkg::SIMPLE_IDX[s]) begin
               rd_val = simple_q[s];
            end
         end
         unique case (eff_idx)
            bk1sf_pkg::IDX_PC_LOW:      rd_val = pc_ff[7:0];
            bk1sf_pkg::IDX_FLAGS_BANK:  rd_val = flags_ff;
            bk1sf_pkg::IDX_IND_POINTER: rd_val = pointer_ff;
            bk1sf_pkg::IDX_UPPER_PC:    rd_val = upper_pc_ff;
            bk1sf_pkg::IDX_IRQ_CONTROL: rd_val = irq_ctrl_ff;
            bk1sf_pkg::IDX_RESET_CAUSE: rd_val = {6'h00, cause_ff};
            bk1sf_pkg::IDX_SSP_STATE:   rd_val = {2'b00, ssp_state_ff};
            bk1sf_pkg::IDX_TX_CONTROL:
               rd_val[bk1sf_pkg::TX_SHIFT_EMPTY_BIT] = tx_empty_ff;
            default: ;
         endcase
      end
   end

   // read data captured in the wait cycle and held for the release edge
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rdata_ff <= 8'h00;
      end else if (avs_read && !ack_ff) begin
         rdata_ff <= rd_val;
      end
   end
   assign avs_readdata = {24'h000000, rdata_ff};

   // plain registers: same value on every reset class
   generate
      for (genvar g = 0; g < bk1sf_pkg::N_SIMPLE; g++) begin : g_cell
         assign simple_we[g] = wr_commit &&
                               (eff_idx == bk1sf_pkg::SIMPLE_IDX[g]);
         bk1sf_reg_cell #(
            .RESET_VAL (bk1sf_pkg::SIMPLE_RST[g]),
            .MASK      (bk1sf_pkg::SIMPLE_MSK[g])
         ) u_cell (
            .clock   (clock),
            .rst     (any_rst),
            .wr_en   (simple_we[g]),
            .wr_data (wdata),
            .q       (simple_q[g])
         );
      end
   endgenerate

   // flags and bank: timeout and power-down follow the reset cause,
   // arithmetic flags survive other resets; both timer bits are read-only
   always_ff @(posedge clock) begin
      if (por_rst) begin
         flags_ff <= bk1sf_pkg::FLAGS_RST;
      end else if (oth_rst) begin
         flags_ff[7:5] <= 3'b000;
         flags_ff[bk1sf_pkg::FB_TIMEOUT]   <= !watchdog_timeout;
         flags_ff[bk1sf_pkg::FB_POWERDOWN] <= !asleep;
      end else if (wr_commit && eff_idx == bk1sf_pkg::IDX_FLAGS_BANK) begin
         flags_ff[7:5] <= wdata[7:5];
         flags_ff[2:0] <= wdata[2:0];
      end
   end

   // indirect pointer keeps its value over other resets
   always_ff @(posedge clock) begin
      if (por_rst) begin
         pointer_ff <= bk1sf_pkg::POINTER_RST;
      end else if (oth_rst) begin
         pointer_ff <= pointer_ff;
      end else if (wr_commit && eff_idx == bk1sf_pkg::IDX_IND_POINTER) begin
         pointer_ff <= wdata;
      end
   end

   // upper pc latch holds five bits only
   always_ff @(posedge clock) begin
      if (any_rst) begin
         upper_pc_ff <= bk1sf_pkg::UPPER_PC_RST;
      end else if (wr_commit && eff_idx == bk1sf_pkg::IDX_UPPER_PC) begin
         upper_pc_ff <= {3'b000, wdata[bk1sf_pkg::UPPER_PC_W-1:0]};
      end
   end

   // program counter: a low-byte write pulls the latch into bits 12:8
   always_ff @(posedge clock) begin
      if (any_rst) begin
         pc_ff <= bk1sf_pkg::PC_RST;
      end else if (wr_commit && eff_idx == bk1sf_pkg::IDX_PC_LOW) begin
         pc_ff <= {upper_pc_ff[bk1sf_pkg::UPPER_PC_W-1:0], wdata};
      end else if (pc_step) begin
         pc_ff <= bk1sf_pkg::PC_W'(pc_ff + bk1sf_pkg::PC_ONE);
      end
   end

   // interrupt control: bit 0 survives other resets
   always_ff @(posedge clock) begin
      if (por_rst) begin
         irq_ctrl_ff <= bk1sf_pkg::IRQ_CTRL_RST;
      end else if (oth_rst) begin
         irq_ctrl_ff <= {7'h00, irq_ctrl_ff[0]};
      end else if (wr_commit && eff_idx == bk1sf_pkg::IDX_IRQ_CONTROL) begin
         irq_ctrl_ff <= wdata;
      end
   end

   // reset cause flags: cleared by their own cause, set by software
   always_ff @(posedge clock) begin
      if (!nrst) begin
         cause_ff <= 2'b00;
      end else if (brown_out_reset) begin
         cause_ff[bk1sf_pkg::RC_BROWN_OUT_BIT] <= 1'b0;
      end else if (oth_rst) begin
         cause_ff <= cause_ff;
      end else if (wr_commit && eff_idx == bk1sf_pkg::IDX_RESET_CAUSE) begin
         cause_ff <= wdata[1:0];
      end
   end

   // peripheral status sampled so bus reads come from flops
   always_ff @(posedge clock) begin
      if (any_rst) begin
         ssp_state_ff <= 6'h00;
         tx_empty_ff  <= 1'b1;
      end else begin
         ssp_state_ff <= ssp_state_in;
         tx_empty_ff  <= tx_shift_empty;
      end
   end

   // contents out to the core and peripherals
   always_comb begin
      regs             = '0;
      regs.simple      = simple_q;
      regs.flags_bank  = flags_ff;
      regs.ind_pointer = pointer_ff;
      regs.upper_pc    = upper_pc_ff;
      regs.irq_control = irq_ctrl_ff;
      regs.reset_cause = {6'h00, cause_ff};
      regs.pc          = pc_ff;
      regs.simple[bk1sf_pkg::SL_TX_CTL][bk1sf_pkg::TX_SHIFT_EMPTY_BIT] =
         tx_empty_ff;
   end

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   logic rd_done;
   logic wr_done;
   assign rd_done = avs_read && !avs_waitrequest;
   assign wr_done = avs_write && !avs_waitrequest;

   chk_wait_bounded: assert property (
      req && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held more than one cycle");

   chk_hole_reads_zero: assert property (
      rd_done && !acc_ok |-> avs_readdata == 32'h00000000)
      else $error("unmapped read returned nonzero");

   chk_high_bits_zero: assert property (
      rd_done |-> avs_readdata[31:8] == 24'h000000 &&
      (!acc_ok || eff_idx != bk1sf_pkg::IDX_PORT_A_DIR ||
       avs_readdata[7:6] == 2'b00))
      else $error("unused data bits not zero");

   chk_mirror_flags: assert property (
      wr_done && bus_idx == 8'h03 && avs_byteenable[0] && !any_rst
      |=> flags_ff[bk1sf_pkg::FB_ZERO] == $past(avs_writedata[2]))
      else $error("bank 0 mirror write missed flags register");

   chk_pc_load: assert property (
      wr_commit && eff_idx == bk1sf_pkg::IDX_PC_LOW
      |=> pc_ff == {$past(upper_pc_ff[4:0]), $past(wdata)})
      else $error("pc load did not take upper latch");

   chk_latch_narrow: assert property (
      upper_pc_ff[7:5] == 3'b000 ##1 rd_done && acc_ok &&
      eff_idx == bk1sf_pkg::IDX_UPPER_PC |-> avs_readdata[7:5] == 3'b000)
      else $error("upper pc latch shows hidden bits");

   chk_other_values: assert property (
      oth_rst && !por_rst |=> simple_q[bk1sf_pkg::SL_OPTIONS] == 8'hff &&
      irq_ctrl_ff[7:1] == 7'h00 && pc_ff == bk1sf_pkg::PC_RST)
      else $error("other reset values not loaded");

   chk_other_keeps: assert property (
      oth_rst && !por_rst |=> $stable(pointer_ff) && $stable(cause_ff) &&
      flags_ff[bk1sf_pkg::FB_TIMEOUT] == !$past(watchdog_timeout))
      else $error("other reset disturbed kept or conditional bits");

   chk_hole_write: assert property (
      wr_done && !acc_ok && !any_rst && !pc_step
      |=> $stable(simple_q) && $stable(pointer_ff) && $stable(flags_ff) &&
          $stable(upper_pc_ff) && $stable(irq_ctrl_ff) && $stable(pc_ff))
      else $error("unmapped write changed a register");

   cov_indirect_read: cover property (
      rd_done && direct_map[7:0] == bk1sf_pkg::IDX_INDIRECT_DATA && acc_ok);
   cov_pc_jump: cover property (
      wr_commit && eff_idx == bk1sf_pkg::IDX_PC_LOW);
   cov_watchdog: cover property (watchdog_timeout && !por_rst);
   cov_mirror_read: cover property (rd_done && !bus_idx[7] && acc_ok);

endmodule
`default_nettype wire

// ---- test/bk1sf_bank_test.sv ----
// self-checking bench for the bank 1 special function register block
`timescale 1ns/1ps
`default_nettype none
module bk1sf_bank_test;
   // clock and reset causes
   logic                   clock;
   logic                   nrst;
   logic                   brown_out_reset;
   logic                   external_clear_pin;
   logic                   watchdog_timeout;
   logic                   asleep;
   // core and peripheral side
   logic                   pc_step;
   logic [5:0]             ssp_state_in;
   logic                   tx_shift_empty;
   // avalon-mm master side
   logic [9:0]             avs_address;
   logic                   avs_read;
   logic                   avs_write;
   logic [31:0]            avs_writedata;
   logic [3:0]             avs_byteenable;
   logic [31:0]            avs_readdata;
   logic                   avs_waitrequest;
   bk1sf_pkg::bk1sf_regs_t regs;
   // result counters
   int                     miscompares;
   int                     comparisons;

   // 100 MHz clock
   initial clock = 1'b0;
   always #5 clock = ~clock;

   bk1sf_bank i_bk1sf_bank (
      .clock(clock), .nrst(nrst), .brown_out_reset(brown_out_reset),
      .external_clear_pin(external_clear_pin),
      .watchdog_timeout(watchdog_timeout), .asleep(asleep),
      .pc_step(pc_step), .ssp_state_in(ssp_state_in),
      .tx_shift_empty(tx_shift_empty), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .regs(regs));

   // verdict; the only place the run ends
   task automatic tally_and_finish();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // value compare, four-state exact
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // waits for the commit edge; a stuck slave ends the run
   task automatic wait_ack();
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         miscompares++;
         $display("mismatch waitrequest expected 0 seen %b", avs_waitrequest);
         tally_and_finish();
      end
   endtask

   // one write; an idle edge follows so strobes never toggle twice a step
   task automatic bus_write(input logic [7:0] idx, input logic [7:0] data,
                            input logic [3:0] be = 4'hf);
      avs_address    <= {idx, 2'b00};
      avs_writedata  <= {24'h000000, data};
      avs_byteenable <= be;
      avs_write      <= 1'b1;
      wait_ack();
      avs_write      <= 1'b0;
      @(posedge clock);
   endtask

   // one read, data taken at the commit edge, then compared
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] got;
      avs_address <= {idx, 2'b00};
      avs_read    <= 1'b1;
      wait_ack();
      got = avs_readdata;
      avs_read    <= 1'b0;
      @(posedge clock);
      check($sformatf("reg %h", idx), {24'h000000, exp}, got);
   endtask

   // one-cycle pulse of {brown-out, clear pin, watchdog}
   task automatic pulse_reset(input logic [2:0] cause);
      {brown_out_reset, external_clear_pin, watchdog_timeout} <= cause;
      @(posedge clock);
      {brown_out_reset, external_clear_pin, watchdog_timeout} <= 3'b000;
      @(posedge clock);
   endtask

   // power-on values of every implemented register except the indirect data port
   task automatic test_por();
      logic [7:0] idx [17];
      logic [7:0] val [17];
      idx = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h8a,
              8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h92, 8'h93, 8'h94, 8'h98, 8'h99};
      val = '{8'hff, 8'h00, 8'h18, 8'h00, 8'h3f, 8'hff, 8'hff, 8'h00,
              8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h02, 8'h00};
      for (int i = 0; i < 17; i++) begin
         rd(idx[i], val[i]);
      end
      $display("test power-on values done");
   endtask

   // holes in the map read zero and swallow writes
   task automatic test_unmapped();
      logic [7:0] hole [12];
      hole = '{8'h88, 8'h89, 8'h8f, 8'h90, 8'h91, 8'h95, 8'h96, 8'h97,
               8'h9a, 8'h9f, 8'h05, 8'ha0};
      for (int i = 0; i < 12; i++) begin
         bus_write(hole[i], 8'ha5);
         rd(hole[i], 8'h00);
      end
      $display("test unmapped done");
   endtask

   // unimplemented bits, read-only places and a lane-0-less write
   task automatic test_bits();
      ssp_state_in   <= 6'h2a;
      tx_shift_empty <= 1'b0;
      @(posedge clock);
      bus_write(8'h85, 8'hc0);
      rd(8'h85, 8'h00);
      bus_write(8'h8d, 8'hff);
      rd(8'h8d, 8'h01);
      bus_write(8'h94, 8'hff);
      rd(8'h94, 8'h2a);
      bus_write(8'h98, 8'hff);
      rd(8'h98, 8'hf5);
      bus_write(8'h93, 8'h77, 4'he);
      rd(8'h93, 8'h00);
      bus_write(8'h8c, 8'h3f);
      rd(8'h8c, 8'h3f);
      check("regs tx", 32'hf5, {24'h0, regs.simple[bk1sf_pkg::SL_TX_CTL]});
      $display("test bits done");
   endtask

   // latch reaches pc high bits only through a pc low write
   task automatic test_pc();
      bus_write(8'h0a, 8'hff);
      rd(8'h8a, 8'h1f);
      check("pc untouched", 32'h0, {19'h0, regs.pc});
      bus_write(8'h82, 8'h34);
      check("pc loaded", 32'h1f34, {19'h0, regs.pc});
      pc_step <= 1'b1;
      @(posedge clock);
      pc_step <= 1'b0;
      @(posedge clock);
      check("pc stepped", 32'h1f35, {19'h0, regs.pc});
      rd(8'h02, 8'h35);
      $display("test program counter done");
   endtask

   // indirect port through the pointer, from both banks
   task automatic test_indirect();
      bus_write(8'h84, 8'h92);
      bus_write(8'h80, 8'h5a);
      rd(8'h92, 8'h5a);
      rd(8'h00, 8'h5a);
      bus_write(8'h04, 8'h80);
      rd(8'h84, 8'h80);
      rd(8'h80, 8'h00);
      bus_write(8'h03, 8'h04);
      rd(8'h83, 8'h1c);
      $display("test indirect done");
   endtask

   // watchdog, clear pin, then brown-out; select bits kept clear
   task automatic test_other_resets();
      bus_write(8'h83, 8'h07);
      bus_write(8'h84, 8'h55);
      bus_write(8'h81, 8'h00);
      bus_write(8'h8b, 8'hff);
      bus_write(8'h8e, 8'h03);
      bus_write(8'h8a, 8'h0c);
      asleep <= 1'b0;
      pulse_reset(3'b001);
      rd(8'h83, 8'h0f);
      rd(8'h84, 8'h55);
      rd(8'h81, 8'hff);
      rd(8'h8b, 8'h01);
      rd(8'h8e, 8'h03);
      rd(8'h8a, 8'h00);
      asleep <= 1'b1;
      pulse_reset(3'b010);
      rd(8'h83, 8'h17);
      asleep <= 1'b0;
      pulse_reset(3'b100);
      rd(8'h83, 8'h18);
      rd(8'h8e, 8'h02);
      rd(8'h84, 8'h00);
      $display("test other resets done");
   endtask

   // main sequence
   initial begin
      miscompares = 0;
      comparisons = 0;
      nrst = 1'b0;
      {brown_out_reset, external_clear_pin, watchdog_timeout} = 3'b000;
      asleep = 1'b0;
      pc_step = 1'b0;
      ssp_state_in = 6'h00;
      tx_shift_empty = 1'b1;
      avs_address = 10'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hf;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      test_por();
      test_unmapped();
      test_por();
      test_bits();
      test_pc();
      test_indirect();
      test_other_resets();
      tally_and_finish();
   end
endmodule
`default_nettype wire
